// ==== hdl/fld_ctrl.sv ====
// flash led driver control: bus slave on the link clock, registers,
// drive selection, flash timeout and gain selection on the core clock
// assumes scl/sda oversampled by link_clk_i; strobe, tx and headroom async
`timescale 1ns/10ps
`include "fld_defs.svh"

// Function
// R1: start is sda falling while scl high
// R2: stop is sda rising while scl high
// R3: bus busy from start until stop
// R4: repeated start restarts address reception
// R5: master keeps sda stable while scl high
// R6: eight bits msb first, then ack slot
// R7: master clocks ack pulse, releases sda
// R8: slave pulls sda low on ninth pulse
// R9: first byte is address, answer only 53h
// R10: eighth bit zero write, one read
// R11: second byte selects register address
// R12: third byte is written to register
// R13: four modes shutdown torch flash indicator
// R14: strobe pin forces flash drive
// R15: tx high reduces flash to torch current
// R16: strobe low follows programmed mode
// R17: strobe alone gives timed flash
// R18: strobe and tx give timed torch
// R19: gains unity, one and half, double
// R20: low headroom steps gain up one
// R21: gain never steps down while enabled
// R22: disable then enable resets gain minimum
// R23: mode bits decode to four modes
// R24: mode bit three inhibits strobe pin
// R25: timeout kills sink until re-enable
// R26: timeout code selects eight durations
// R27: async pins pass two-flop synchronisers
// R28: foreign address not acked, transfer ignored
module fld_ctrl #(
    parameter int unsigned CYC_PER_MS = `FLD_CYC_PER_MS
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               link_clk_i,
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe_o,
    output logic                    bus_busy_o,
    input  wire logic               strobe_i,
    input  wire logic               tx_i,
    input  wire logic               sink_headroom_low_i,
    output fld_pkg::fld_drive_t     drive_mode_o,
    output logic [3:0]              drive_level_o,
    output logic                    sink_en_o,
    output fld_pkg::fld_gain_t      gain_o,
    output logic                    timed_out_o
);

    // ------------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------------
    logic [1:0]                lsync;
    logic                      scl_s;
    logic                      sda_s;
    logic                      scl_d_q;
    logic                      sda_d_q;
    fld_pkg::fld_link_st_t     lst_q;
    fld_pkg::fld_link_st_t     lst_d;
    logic [3:0]                cnt_q;
    logic [3:0]                cnt_d;
    logic [7:0]                shreg_q;
    logic [7:0]                shreg_d;
    logic [1:0]                idx_q;
    logic [1:0]                idx_d;
    logic                      rw_q;
    logic                      rw_d;
    logic                      oe_q;
    logic                      oe_d;
    logic                      busy_q;
    logic                      sda_out_q;
    fld_pkg::fld_wr_t          wr_q;
    fld_pkg::fld_wr_t          wr_d;
    logic                      tgl_q;
    logic                      tgl_d;

    fld_sync2 #(
        .W (2)
    ) u_link_sync (
        .clk_i   (link_clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({sda_i, scl_i}),
        .q_o     (lsync)
    );

    assign scl_s = lsync[0];
    assign sda_s = lsync[1];

    wire scl_rise = scl_s & ~scl_d_q;
    wire scl_fall = ~scl_s & scl_d_q;
    wire start_w  = scl_s & scl_d_q & sda_d_q & ~sda_s;   // R1
    wire stop_w   = scl_s & scl_d_q & ~sda_d_q & sda_s;   // R2
    wire byte_end = (cnt_q == `FLD_BYTE_BITS);            // R6
    wire addr_hit = (shreg_q[7:1] == `FLD_I2C_ADDR);      // R9

    always_comb begin
        lst_d   = lst_q;
        cnt_d   = cnt_q;
        shreg_d = shreg_q;
        idx_d   = idx_q;
        rw_d    = rw_q;
        oe_d    = oe_q;
        wr_d    = wr_q;
        tgl_d   = tgl_q;
        if (start_w) begin
            // repeated start behaves as a first start
            lst_d = fld_pkg::FLD_LNK_RX;                  // R4
            cnt_d = 4'h0;
            idx_d = 2'h0;
            oe_d  = 1'b0;
        end else if (stop_w) begin
            lst_d = fld_pkg::FLD_LNK_IDLE;
            oe_d  = 1'b0;
        end else begin
            case (lst_q)
                fld_pkg::FLD_LNK_RX: begin
                    if (scl_rise && !byte_end) begin
                        shreg_d = {shreg_q[6:0], sda_s};   // R6
                        cnt_d   = cnt_q + 4'h1;
                    end else if (scl_fall && byte_end) begin
                        cnt_d = 4'h0;
                        if (idx_q != 2'h2) begin
                            idx_d = idx_q + 2'h1;
                        end
                        if (idx_q == 2'h0) begin
                            if (addr_hit) begin
                                rw_d  = shreg_q[0];                // R10
                                oe_d  = 1'b1;                      // R8
                                lst_d = fld_pkg::FLD_LNK_ACK;
                            end else begin
                                lst_d = fld_pkg::FLD_LNK_IGN;      // R28
                            end
                        end else if (idx_q == 2'h1) begin
                            wr_d.addr = shreg_q;                   // R11
                            oe_d      = 1'b1;                      // R8
                            lst_d     = fld_pkg::FLD_LNK_ACK;
                        end else begin
                            wr_d.data = shreg_q;                   // R12
                            tgl_d     = ~tgl_q;
                            oe_d      = 1'b1;                      // R8
                            lst_d     = fld_pkg::FLD_LNK_ACK;
                        end
                    end
                end
                fld_pkg::FLD_LNK_ACK: begin
                    // hold low for the whole ninth pulse, release on its fall
                    if (scl_fall) begin
                        oe_d  = 1'b0;                              // R8
                        lst_d = rw_q ? fld_pkg::FLD_LNK_IGN
                                     : fld_pkg::FLD_LNK_RX;        // R10
                    end
                end
                default: begin
                    lst_d = lst_q;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_d_q   <= 1'b1;
            sda_d_q   <= 1'b1;
            lst_q     <= fld_pkg::FLD_LNK_IDLE;
            cnt_q     <= 4'h0;
            shreg_q   <= 8'h00;
            idx_q     <= 2'h0;
            rw_q      <= 1'b0;
            oe_q      <= 1'b0;
            wr_q      <= '0;
            tgl_q     <= 1'b0;
            sda_out_q <= 1'b0;
        end else begin
            scl_d_q   <= scl_s;
            sda_d_q   <= sda_s;
            lst_q     <= lst_d;
            cnt_q     <= cnt_d;
            shreg_q   <= shreg_d;
            idx_q     <= idx_d;
            rw_q      <= rw_d;
            oe_q      <= oe_d;
            wr_q      <= wr_d;
            tgl_q     <= tgl_d;
            sda_out_q <= 1'b0;
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
        end else if (start_w) begin
            busy_q <= 1'b1;                                // R3
        end else if (stop_w) begin
            busy_q <= 1'b0;                                // R3
        end
    end

    assign sda_o      = sda_out_q;
    assign sda_oe_o   = oe_q;
    assign bus_busy_o = busy_q;

    // ------------------------------------------------------------------
    // core domain
    // ------------------------------------------------------------------
    logic [3:0]                csync;
    logic                      strobe_s;
    logic                      tx_s;
    logic                      head_s;
    logic                      tgl_s;
    logic                      tgl_seen_q;
    logic [3:0]                mode_q;
    logic [3:0]                torch_q;
    logic [3:0]                flash_q;
    logic [3:0]                tmo_q;
    fld_pkg::fld_drive_t       drive_q;
    logic [3:0]                level_q;
    logic                      sink_q;
    fld_pkg::fld_gain_t        gain_q;
    logic [4:0]                settle_q;
    logic                      tout_q;
    logic [13:0]               pre_q;
    logic [10:0]               ms_q;

    fld_sync2 #(
        .W (4)
    ) u_core_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({tgl_q, sink_headroom_low_i, tx_i, strobe_i}),   // R27
        .q_o     (csync)
    );

    assign strobe_s = csync[0];
    assign tx_s     = csync[1];
    assign head_s   = csync[2];
    assign tgl_s    = csync[3];

    // write arrives as a toggle; address and data are stable by then
    wire wr_fire   = tgl_s ^ tgl_seen_q;
    wire we_mode   = wr_fire && (wr_q.addr == `FLD_OFS_MODE);
    wire we_torch  = wr_fire && (wr_q.addr == `FLD_OFS_TORCH);
    wire we_flash  = wr_fire && (wr_q.addr == `FLD_OFS_FLASH);
    wire we_tmo    = wr_fire && (wr_q.addr == `FLD_OFS_TMO);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_seen_q <= 1'b0;
            mode_q     <= `FLD_RST_MODE;
            torch_q    <= `FLD_RST_TORCH;
            flash_q    <= `FLD_RST_FLASH;
            tmo_q      <= `FLD_RST_TMO;
        end else begin
            tgl_seen_q <= tgl_s;
            if (we_mode)  mode_q  <= wr_q.data[3:0];     // R12
            if (we_torch) torch_q <= wr_q.data[3:0];     // R12
            if (we_flash) flash_q <= wr_q.data[3:0];     // R12
            if (we_tmo)   tmo_q   <= wr_q.data[3:0];     // R12
        end
    end

    // mode decode
    wire mode_on    = mode_q[`FLD_MODE_ON];                                // R23
    wire prog_flash = mode_on & mode_q[`FLD_MODE_FLASH];                   // R23
    wire prog_torch = mode_on & ~mode_q[`FLD_MODE_FLASH] & ~mode_q[`FLD_MODE_IND];
    wire prog_ind   = mode_on & ~mode_q[`FLD_MODE_FLASH] & mode_q[`FLD_MODE_IND];
    wire strobe_act = strobe_s & ~mode_q[`FLD_MODE_INHIBIT];               // R24

    // strobe overrides the programmed mode; tx caps flash at torch
    wire fld_pkg::fld_drive_t flash_or_torch =
        tx_s ? fld_pkg::FLD_DRV_TORCH : fld_pkg::FLD_DRV_FLASH;            // R15
    wire fld_pkg::fld_drive_t req_drive =
        strobe_act ? flash_or_torch :                                      // R14
        prog_flash ? flash_or_torch :                                      // R16
        prog_torch ? fld_pkg::FLD_DRV_TORCH :                              // R13
        prog_ind   ? fld_pkg::FLD_DRV_IND :                                // R13
                     fld_pkg::FLD_DRV_OFF;                                 // R13

    wire enabled  = (req_drive != fld_pkg::FLD_DRV_OFF);
    // strobe drive (flash or torch) and programmed flash are time limited
    wire timed_w  = strobe_act | prog_flash;                               // R17 R18

    wire fld_pkg::fld_drive_t drive_d =
        tout_q ? fld_pkg::FLD_DRV_OFF : req_drive;                         // R25
    wire [3:0] level_d =
        (drive_d == fld_pkg::FLD_DRV_FLASH) ? flash_q :
        (drive_d == fld_pkg::FLD_DRV_TORCH) ? torch_q : 4'h0;              // R15

    // timeout duration lookup
    wire [10:0] tmo_lim =
        (tmo_q[2:0] == 3'h0) ? `FLD_TMO_MS0 :
        (tmo_q[2:0] == 3'h1) ? `FLD_TMO_MS1 :
        (tmo_q[2:0] == 3'h2) ? `FLD_TMO_MS2 :
        (tmo_q[2:0] == 3'h3) ? `FLD_TMO_MS3 :
        (tmo_q[2:0] == 3'h4) ? `FLD_TMO_MS4 :
        (tmo_q[2:0] == 3'h5) ? `FLD_TMO_MS5 :
        (tmo_q[2:0] == 3'h6) ? `FLD_TMO_MS6 : `FLD_TMO_MS7;               // R26
    wire pre_wrap = (pre_q == 14'(CYC_PER_MS - 1));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_q  <= 14'h0000;
            ms_q   <= 11'h000;
            tout_q <= 1'b0;
        end else if (!enabled) begin
            pre_q  <= 14'h0000;
            ms_q   <= 11'h000;
            tout_q <= 1'b0;                                        // R25
        end else if (!timed_w || tout_q) begin
            pre_q  <= 14'h0000;
            ms_q   <= 11'h000;
        end else if (ms_q == tmo_lim) begin
            tout_q <= 1'b1;                                        // R25
        end else if (pre_wrap) begin
            pre_q  <= 14'h0000;
            ms_q   <= ms_q + 11'h001;
        end else begin
            pre_q  <= pre_q + 14'h0001;
        end
    end

    // gain steps up only; a settle gap lets the pump respond first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain_q   <= fld_pkg::FLD_GAIN_1X;
            settle_q <= 5'h00;
        end else if (!enabled) begin
            gain_q   <= fld_pkg::FLD_GAIN_1X;                      // R22
            settle_q <= 5'h00;
        end else if (settle_q != 5'h00) begin
            settle_q <= settle_q - 5'h01;                          // R21
        end else if (head_s && gain_q != fld_pkg::FLD_GAIN_2X) begin
            gain_q   <= (gain_q == fld_pkg::FLD_GAIN_1X) ?
                        fld_pkg::FLD_GAIN_15X : fld_pkg::FLD_GAIN_2X;   // R19 R20
            settle_q <= 5'(`FLD_GAIN_SETTLE_CYC);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_q <= fld_pkg::FLD_DRV_OFF;
            level_q <= 4'h0;
            sink_q  <= 1'b0;
        end else begin
            drive_q <= drive_d;                                    // R17 R18
            level_q <= level_d;
            sink_q  <= (drive_d != fld_pkg::FLD_DRV_OFF);          // R25
        end
    end

    assign drive_mode_o  = drive_q;
    assign drive_level_o = level_q;
    assign sink_en_o     = sink_q;
    assign gain_o        = gain_q;
    assign timed_out_o   = tout_q;

endmodule

// ==== hdl/fld_defs.svh ====
// constants for the flash led driver control block
// assumes a 10 MHz core clock; included by the control module and the bench top
`ifndef FLD_DEFS_SVH
`define FLD_DEFS_SVH

// bus address of the slave
`define FLD_I2C_ADDR        7'h53

// register offsets
`define FLD_OFS_MODE        8'h10
`define FLD_OFS_TORCH       8'hA0
`define FLD_OFS_FLASH       8'hB0
`define FLD_OFS_TMO         8'hC0

// reset values
`define FLD_RST_MODE        4'h0
`define FLD_RST_TORCH       4'h7
`define FLD_RST_FLASH       4'hA
`define FLD_RST_TMO         4'hB

// mode register fields
`define FLD_MODE_ON         0
`define FLD_MODE_FLASH      1
`define FLD_MODE_IND        2
`define FLD_MODE_INHIBIT    3

// bits per byte before the acknowledge slot
`define FLD_BYTE_BITS       4'h8

// timing
`define FLD_CLK_PERIOD_NS   100
`define FLD_MS_NS           1000000
`define FLD_CYC_PER_MS      (`FLD_MS_NS / `FLD_CLK_PERIOD_NS)
`define FLD_GAIN_SETTLE_NS  2000
`define FLD_GAIN_SETTLE_CYC \
    ((`FLD_GAIN_SETTLE_NS + `FLD_CLK_PERIOD_NS - 1) / `FLD_CLK_PERIOD_NS)

// timeout durations in ms, codes 0 to 7
`define FLD_TMO_MS0         11'h03C
`define FLD_TMO_MS1         11'h07D
`define FLD_TMO_MS2         11'h0FA
`define FLD_TMO_MS3         11'h177
`define FLD_TMO_MS4         11'h1F4
`define FLD_TMO_MS5         11'h271
`define FLD_TMO_MS6         11'h2EE
`define FLD_TMO_MS7         11'h44C

`endif

// ==== hdl/fld_pkg.sv ====
// types shared by the flash led driver control files
// assumes nothing beyond a SystemVerilog tool
package fld_pkg;

    typedef enum logic [3:0] {
        FLD_DRV_OFF   = 4'b0001,
        FLD_DRV_TORCH = 4'b0010,
        FLD_DRV_FLASH = 4'b0100,
        FLD_DRV_IND   = 4'b1000
    } fld_drive_t;

    typedef enum logic [2:0] {
        FLD_GAIN_1X  = 3'b001,
        FLD_GAIN_15X = 3'b010,
        FLD_GAIN_2X  = 3'b100
    } fld_gain_t;

    typedef enum logic [3:0] {
        FLD_LNK_IDLE = 4'b0001,
        FLD_LNK_RX   = 4'b0010,
        FLD_LNK_ACK  = 4'b0100,
        FLD_LNK_IGN  = 4'b1000
    } fld_link_st_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } fld_wr_t;

endpackage

// ==== hdl/fld_sync2.sv ====
// two-flop synchroniser, W bits wide
// assumes each bit is an independent level
`timescale 1ns/10ps
module fld_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] q_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_q    <= '0;
        end else begin
            meta_q <= d_i;
            q_q    <= meta_q;
        end
    end

    assign q_o = q_q;
endmodule

// ==== tb/fld_ctrl_asserts.sv ====
// port checks for fld_ctrl: bus side on link_clk_i, drive side on clk_i
// assumes sda_i is the resolved wire; bound into every fld_ctrl below
`timescale 1ns/10ps
module fld_ctrl_asserts #(
    parameter int unsigned CYC_PER_MS = 10000
) (
    input wire logic                clk_i,
    input wire logic                rst_n_i,
    input wire logic                link_clk_i,
    input wire logic                scl_i,
    input wire logic                sda_i,
    input wire logic                sda_o,
    input wire logic                sda_oe_o,
    input wire logic                bus_busy_o,
    input wire logic                strobe_i,
    input wire logic                tx_i,
    input wire logic                sink_headroom_low_i,
    input wire fld_pkg::fld_drive_t drive_mode_o,
    input wire logic [3:0]          drive_level_o,
    input wire logic                sink_en_o,
    input wire fld_pkg::fld_gain_t  gain_o,
    input wire logic                timed_out_o
);
    sequence s_start;
        scl_i && $fell(sda_i);
    endsequence
    sequence s_stop;
        scl_i && $rose(sda_i);
    endsequence

    a_busy_on_start: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        s_start |-> ##[1:8] bus_busy_o) else $error("bus not busy after start");
    a_free_on_stop: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        s_stop |-> ##[1:8] !bus_busy_o) else $error("bus not free after stop");
    a_ack_rise_low: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $rose(sda_oe_o) |-> !scl_i) else $error("ack began with scl high");
    a_ack_fall_low: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $fell(sda_oe_o) |-> !scl_i) else $error("ack ended with scl high");
    a_ack_pulls_busy: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        sda_oe_o |-> !sda_o && bus_busy_o) else $error("sda driven outside a transfer");
    a_off_no_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        drive_mode_o == fld_pkg::FLD_DRV_OFF |-> drive_level_o == 4'h0 && !sink_en_o)
        else $error("off mode still drives");
    a_ind_no_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        drive_mode_o == fld_pkg::FLD_DRV_IND |-> drive_level_o == 4'h0 && sink_en_o)
        else $error("indicator level wrong");
    a_timeout_dark: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        timed_out_o [*2] |-> !sink_en_o) else $error("sink on while timed out");
    a_gain_no_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sink_en_o && $past(sink_en_o) |-> gain_o >= $past(gain_o))
        else $error("gain dropped while enabled");
    a_gain_min_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (drive_mode_o == fld_pkg::FLD_DRV_OFF && !timed_out_o) [*3]
        |-> gain_o == fld_pkg::FLD_GAIN_1X) else $error("gain not minimum when off");
    a_gain_one_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        gain_o == fld_pkg::FLD_GAIN_2X |-> $past(gain_o) != fld_pkg::FLD_GAIN_1X)
        else $error("gain skipped a step");
endmodule

bind fld_ctrl fld_ctrl_asserts #(.CYC_PER_MS(CYC_PER_MS)) u_asserts (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .bus_busy_o(bus_busy_o),
    .strobe_i(strobe_i), .tx_i(tx_i), .sink_headroom_low_i(sink_headroom_low_i),
    .drive_mode_o(drive_mode_o), .drive_level_o(drive_level_o), .sink_en_o(sink_en_o),
    .gain_o(gain_o), .timed_out_o(timed_out_o)
);

// ==== tb/fld_i2c_mst.sv ====
// bus master model driving scl and sda of the flash led driver
// assumes the bench resolves sda with a pull-up and feeds it back
`timescale 1ns/10ps
module fld_i2c_mst #(
    parameter int Q = 625
) (
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // start or repeated start, leaves scl low
    task automatic start();
        sda_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_o = 1'b0;
        #Q scl_o = 1'b0;
        #Q;
    endtask

    task automatic stop();
        sda_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_o = 1'b1;
        #Q;
    endtask

    // ack only if sda is low at both samples taken within the ninth pulse
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic a0;
        for (int i = 7; i >= 0; i--) begin
            sda_o = b[i];
            #Q scl_o = 1'b1;
            #(2*Q) scl_o = 1'b0;
            #Q;
        end
        sda_o = 1'b1;
        #Q scl_o = 1'b1;
        #(Q/2) a0 = !sda_i;
        #Q ack = a0 && !sda_i;
        #(Q/2) scl_o = 1'b0;
        #Q;
    endtask
endmodule

// ==== tb/fld_ctrl_tb_top.sv ====
// self-checking bench for fld_ctrl driven by a bus master model
// assumes the checker binds itself to fld_ctrl
`timescale 1ns/10ps
`include "fld_defs.svh"
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); \
    end \
end

module fld_ctrl_tb_top;
    localparam int         CPM = 10;
    localparam logic [6:0] ADR = `FLD_I2C_ADDR;
    localparam logic [7:0] MOD = `FLD_OFS_MODE;
    logic                clk_i = 1'b0;
    logic                link_clk_i = 1'b0;
    logic                rst_n_i, scl, mst_sda, sda_wire, sda_o, sda_oe_o, bus_busy_o;
    logic                strobe_i, tx_i, hr_low, sink_en_o, timed_out_o;
    logic [3:0]          drive_level_o, sh_mode, sh_torch, sh_flash;
    fld_pkg::fld_drive_t drive_mode_o;
    fld_pkg::fld_gain_t  gain_o;
    logic [31:0]         seed = 32'h0001_5c80;
    int                  n_mismatch = 0;
    int                  cmp_count = 0;
    int                  tmo_tab [8] = '{60, 125, 250, 375, 500, 625, 750, 1100};

    assign sda_wire = mst_sda & (~sda_oe_o | sda_o);
    always #50 clk_i = ~clk_i;
    initial begin
        #7;
        forever #16 link_clk_i = ~link_clk_i;
    end

    fld_ctrl #(.CYC_PER_MS(CPM)) DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl),
        .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .bus_busy_o(bus_busy_o),
        .strobe_i(strobe_i), .tx_i(tx_i), .sink_headroom_low_i(hr_low),
        .drive_mode_o(drive_mode_o), .drive_level_o(drive_level_o), .sink_en_o(sink_en_o),
        .gain_o(gain_o), .timed_out_o(timed_out_o)
    );
    fld_i2c_mst u_mst (.scl_o(scl), .sda_o(mst_sda), .sda_i(sda_wire));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected {mode, level, sink} from shadow registers and pins
    function automatic logic [8:0] exp_drv();
        logic fl;
        fl = (strobe_i && !sh_mode[3]) || (sh_mode[0] && sh_mode[1]);
        if (fl && tx_i) return {fld_pkg::FLD_DRV_TORCH, sh_torch, 1'b1};
        if (fl) return {fld_pkg::FLD_DRV_FLASH, sh_flash, 1'b1};
        if (!sh_mode[0]) return {fld_pkg::FLD_DRV_OFF, 4'h0, 1'b0};
        if (!sh_mode[2]) return {fld_pkg::FLD_DRV_TORCH, sh_torch, 1'b1};
        return {fld_pkg::FLD_DRV_IND, 4'h0, 1'b1};
    endfunction

    task automatic chk_drv();
        repeat (5) @(negedge clk_i);
        `CHK({drive_mode_o, drive_level_o, sink_en_o}, exp_drv())
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d);
        logic ack, hit;
        hit = (a == ADR);
        u_mst.start();
        `CHK(bus_busy_o, 1'b1)
        u_mst.wbyte({a, 1'b0}, ack);
        `CHK(ack, hit)
        u_mst.wbyte(ofs, ack);
        `CHK(ack, hit)
        u_mst.wbyte(d, ack);
        `CHK(ack, hit)
        u_mst.stop();
        `CHK(bus_busy_o, 1'b0)
        if (hit && ofs == MOD) sh_mode = d[3:0];
        if (hit && ofs == `FLD_OFS_TORCH) sh_torch = d[3:0];
        if (hit && ofs == `FLD_OFS_FLASH) sh_flash = d[3:0];
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        results();
    end

    initial begin
        logic        ack;
        logic [31:0] r;
        int          lim;
        {rst_n_i, strobe_i, tx_i, hr_low} = 4'h0;
        {sh_mode, sh_torch, sh_flash} = 12'h07a;
        repeat (3) @(negedge clk_i);
        rst_n_i = 1'b1;
        `CHK({drive_mode_o, gain_o, timed_out_o}, {fld_pkg::FLD_DRV_OFF, 4'h2})
        repeat (5) @(negedge clk_i);
        // longest timeout: the flash stretch below outlasts the reset code
        wr(ADR, `FLD_OFS_TMO, 8'h07);
        wr(ADR, MOD, 8'h01);
        chk_drv();
        wr(ADR, MOD, 8'h03);
        chk_drv();
        r = rnd();
        wr(ADR, `FLD_OFS_TORCH, r[7:0]);
        wr(ADR, `FLD_OFS_FLASH, r[15:8]);
        chk_drv();
        wr(ADR ^ 7'h01, MOD, 8'h00);
        chk_drv();
        wr(ADR, 8'h20, 8'h00);
        chk_drv();
        u_mst.start();
        u_mst.wbyte({ADR, 1'b1}, ack);
        `CHK(ack, 1'b1)
        u_mst.start();
        u_mst.wbyte({ADR, 1'b0}, ack);
        u_mst.wbyte(`FLD_OFS_TORCH, ack);
        wr(ADR, MOD, 8'h01);
        chk_drv();
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            wr(ADR, MOD, {r[7:4], i[3:0]});
            for (int j = 0; j < 4; j++) begin
                @(negedge clk_i);
                {strobe_i, tx_i} = j[1:0];
                hr_low = r[j];
                chk_drv();
            end
        end
        @(negedge clk_i);
        {strobe_i, tx_i, hr_low} = 3'h0;
        wr(ADR, MOD, 8'h00);
        r = rnd();
        wr(ADR, `FLD_OFS_TMO, {7'h00, r[0]});
        lim = tmo_tab[r[0]] * CPM;
        @(negedge clk_i);
        strobe_i = 1'b1;
        repeat (lim - 5) @(negedge clk_i);
        `CHK(timed_out_o, 1'b0)
        repeat (15) @(negedge clk_i);
        `CHK({timed_out_o, sink_en_o}, 2'h2)
        tx_i = 1'b1;
        repeat (5) @(negedge clk_i);
        `CHK(timed_out_o, 1'b1)
        {strobe_i, tx_i} = 2'h0;
        repeat (5) @(negedge clk_i);
        `CHK(timed_out_o, 1'b0)
        strobe_i = 1'b1;
        chk_drv();
        @(negedge clk_i);
        strobe_i = 1'b0;
        wr(ADR, MOD, 8'h01);
        `CHK(gain_o, fld_pkg::FLD_GAIN_1X)
        @(negedge clk_i);
        hr_low = 1'b1;
        repeat (5) @(negedge clk_i);
        `CHK(gain_o, fld_pkg::FLD_GAIN_15X)
        repeat (30) @(negedge clk_i);
        `CHK(gain_o, fld_pkg::FLD_GAIN_2X)
        hr_low = 1'b0;
        repeat (20) @(negedge clk_i);
        `CHK(gain_o, fld_pkg::FLD_GAIN_2X)
        wr(ADR, MOD, 8'h00);
        wr(ADR, MOD, 8'h01);
        `CHK(gain_o, fld_pkg::FLD_GAIN_1X)
        results();
    end
endmodule
